// file: rtl/bcs_addr_gen.sv
`timescale 1ns/100ps
module bcs_addr_gen
(
    // Address request and result
    bcs_addr_if.gen ai
);
    import bcs_pkg::*;

    // Byte offset of word n of an instruction, counting the first as 0
    function automatic logic [ADDR_W-1:0] word_off(input logic [EXT_W-1:0] n);
        word_off = ADDR_W'({21'h000000, n} * WORD_BYTES);
    endfunction

    always_comb
    begin
        case (ai.slot)
            // RULE_02 - extension word addresses
            SLOT_EXT: ai.addr = ai.instr_addr + word_off(ai.ext_idx);
            // RULE_03 - next instruction address
            SLOT_NEXT: ai.addr = ai.instr_addr +
                word_off(ai.ext_words + 3'h1);
            SLOT_EA: ai.addr = ai.eff_addr;
            SLOT_TGT: ai.addr = ai.target;
            default: ai.addr = ai.instr_addr;
        endcase
    end

endmodule // bcs_addr_gen

// file: rtl/bcs_addr_if.sv
`timescale 1ns/100ps
interface bcs_addr_if;
    import bcs_pkg::*;

    logic [ADDR_W-1:0] instr_addr;
    logic [ADDR_W-1:0] eff_addr;
    logic [ADDR_W-1:0] target;
    logic [EXT_W-1:0] ext_idx;
    logic [EXT_W-1:0] ext_words;
    bcs_slot_type slot;
    logic [ADDR_W-1:0] addr;

    modport seq
    (
        output instr_addr,
        output eff_addr,
        output target,
        output ext_idx,
        output ext_words,
        output slot,
        input addr
    );

    modport gen
    (
        input instr_addr,
        input eff_addr,
        input target,
        input ext_idx,
        input ext_words,
        input slot,
        output addr
    );

endinterface

// file: rtl/bcs_pkg.sv
package bcs_pkg;

    // Bus and data widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int EXT_W = 3;

    // Bytes per instruction word
    localparam logic [ADDR_W-1:0] WORD_BYTES = 24'h000002;

    // Highest extension word index (5th word)
    localparam logic [EXT_W-1:0] EXT_MAX = 3'h4;

    // Length of the internal state of a long branch, in states
    localparam int INT_STATES = 1;

    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    // Instruction classes, as far as the bus sequence is concerned
    typedef enum logic [2:0] {
        KIND_PLAIN = 3'h0,
        KIND_BR8 = 3'h1,
        KIND_BR16 = 3'h2,
        KIND_BIT_TEST = 3'h3,
        KIND_BIT_MODIFY = 3'h4
    } bcs_kind_type;

    // Address source of one bus cycle
    typedef enum logic [1:0] {
        SLOT_EXT = 2'h0,
        SLOT_NEXT = 2'h1,
        SLOT_EA = 2'h2,
        SLOT_TGT = 2'h3
    } bcs_slot_type;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_EXT = 3'h1,
        ST_INT = 3'h2,
        ST_OPRD = 3'h3,
        ST_NEXT = 3'h4,
        ST_TGT = 3'h5,
        ST_WR = 3'h6
    } bcs_state_type;

endpackage

// file: rtl/bcs_seq.sv
`timescale 1ns/100ps
// Notes on behaviour
// RULE_01 - After a locked cycle the bus stays owned; no immediate handover.
// RULE_02 - Extension words are word reads, in order, 2nd at bytes 3-4 onward.
// RULE_03 - Every sequence except the long branch includes a word read of the next instruction.
// RULE_04 - Short branch: word read at next address, then at target.
// RULE_05 - Long branch: read 2nd word, one internal state, read target.
// RULE_06 - Bit test on memory: extensions, byte read, locked next prefetch.
// RULE_07 - Bit modify: locked byte read, locked prefetch, byte write back.
// RULE_08 - Cycle length set by the addressed area; order never changes.
module bcs_seq
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic instr_valid,
    input wire bcs_pkg::bcs_kind_type instr_kind,
    input wire logic [bcs_pkg::EXT_W-1:0] ext_words,
    input wire logic [bcs_pkg::ADDR_W-1:0] instr_addr,
    input wire logic [bcs_pkg::ADDR_W-1:0] effective_address,
    input wire logic [bcs_pkg::ADDR_W-1:0] branch_target,
    input wire logic [bcs_pkg::BYTE_W-1:0] wr_byte,
    output logic instr_ready,
    output logic instr_done,
    // System bus
    output logic bus_req,
    output logic [bcs_pkg::ADDR_W-1:0] bus_addr,
    output logic bus_byte,
    output logic bus_write,
    output logic [bcs_pkg::BYTE_W-1:0] bus_wdata,
    output logic bus_lock,
    output logic bus_int,
    input wire logic bus_ack,
    input wire logic [bcs_pkg::DATA_W-1:0] bus_rdata,
    // Read data
    output logic rd_valid,
    output logic [bcs_pkg::DATA_W-1:0] rd_data
);
    import bcs_pkg::*;

    bcs_state_type state_r, state_nxt;
    bcs_kind_type kind_r;
    logic [EXT_W-1:0] ext_words_r;
    logic [EXT_W-1:0] ext_idx_r, ext_idx_nxt;
    logic [ADDR_W-1:0] pc_r, ea_r, tgt_r;
    logic [BYTE_W-1:0] wbyte_r;
    logic req_r, byte_r, write_r, lock_r, int_r, done_r, rdv_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] rdata_r;
    logic next_seen_r;
    logic ready_r;
    logic step;
    logic start;
    bcs_kind_type kind_sel;
    logic [EXT_W-1:0] ext_sel;
    logic cur_locked;

    bcs_addr_if ai ();

    bcs_addr_gen u_addr_gen
    (
        .ai(ai.gen)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state decode

    // State reached once the extension words are done
    function automatic bcs_state_type after_ext(input bcs_kind_type k);
        case (k)
            KIND_BR16: after_ext = ST_INT;
            KIND_BIT_TEST: after_ext = ST_OPRD;
            KIND_BIT_MODIFY: after_ext = ST_OPRD;
            default: after_ext = ST_NEXT;
        endcase
    endfunction

    // RULE_06 - locked prefetch cycles
    // Whether a state's bus cycle is a locked one
    function automatic logic is_locked(input bcs_state_type s,
                                       input bcs_kind_type k);
        is_locked = ((s == ST_OPRD) && (k == KIND_BIT_MODIFY)) ||
            ((s == ST_NEXT) &&
             ((k == KIND_BIT_TEST) || (k == KIND_BIT_MODIFY)));
    endfunction

    assign start = (state_r == ST_IDLE) && instr_valid;
    assign kind_sel = start ? instr_kind : kind_r;
    assign ext_sel = start ? ((instr_kind == KIND_BR16) ? 3'h1 :
        ((instr_kind == KIND_BR8) ? 3'h0 : ext_words)) : ext_words_r;
    // RULE_08 - a cycle ends only when the area reports completion
    assign step = ((state_r == ST_INT) || (req_r && bus_ack));
    assign cur_locked = is_locked(state_r, kind_r);

    always_comb
    begin
        state_nxt = state_r;
        ext_idx_nxt = ext_idx_r;
        case (state_r)
            ST_IDLE:
            begin
                if (instr_valid)
                begin
                    ext_idx_nxt = 3'h1;
                    // RULE_04 - short branch starts with the next fetch
                    if (ext_sel != 3'h0)
                        state_nxt = ST_EXT;
                    else
                        state_nxt = after_ext(kind_sel);
                end
            end
            ST_EXT:
            begin
                if (step)
                begin
                    // RULE_02 - extension words strictly in order
                    if (ext_idx_r < ext_words_r && ext_idx_r < EXT_MAX)
                        ext_idx_nxt = ext_idx_r + 3'h1;
                    else
                        state_nxt = after_ext(kind_r);
                end
            end
            // RULE_05 - one internal state, then the target
            ST_INT: state_nxt = ST_TGT;
            ST_OPRD:
            begin
                if (step)
                    state_nxt = ST_NEXT;
            end
            ST_NEXT:
            begin
                if (step)
                begin
                    if (kind_r == KIND_BR8)
                        state_nxt = ST_TGT;
                    // RULE_07 - write back follows the locked prefetch
                    else if (kind_r == KIND_BIT_MODIFY)
                        state_nxt = ST_WR;
                    else
                        state_nxt = ST_IDLE;
                end
            end
            ST_TGT, ST_WR:
            begin
                if (step)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_comb
    begin
        ai.instr_addr = start ? instr_addr : pc_r;
        ai.eff_addr = start ? effective_address : ea_r;
        ai.target = start ? branch_target : tgt_r;
        ai.ext_idx = ext_idx_nxt;
        ai.ext_words = ext_sel;
        case (state_nxt)
            ST_EXT: ai.slot = SLOT_EXT;
            ST_OPRD, ST_WR: ai.slot = SLOT_EA;
            ST_TGT: ai.slot = SLOT_TGT;
            default: ai.slot = SLOT_NEXT;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            ext_idx_r <= 3'h0;
            ready_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            ext_idx_r <= ext_idx_nxt;
            ready_r <= (state_nxt == ST_IDLE);
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            kind_r <= KIND_PLAIN;
            ext_words_r <= 3'h0;
            pc_r <= ADDR_RST;
            ea_r <= ADDR_RST;
            tgt_r <= ADDR_RST;
            wbyte_r <= 8'h00;
        end
        else if (start)
        begin
            kind_r <= instr_kind;
            ext_words_r <= ext_sel;
            pc_r <= instr_addr;
            ea_r <= effective_address;
            tgt_r <= branch_target;
            wbyte_r <= wr_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle outputs

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_r <= 1'b0;
            addr_r <= ADDR_RST;
            byte_r <= 1'b0;
            write_r <= 1'b0;
            int_r <= 1'b0;
        end
        // RULE_08 - hold the cycle unchanged until it completes
        else if (start || step)
        begin
            req_r <= (state_nxt != ST_IDLE) && (state_nxt != ST_INT);
            addr_r <= ai.addr;
            byte_r <= (state_nxt == ST_OPRD) || (state_nxt == ST_WR);
            write_r <= (state_nxt == ST_WR);
            // RULE_05 - internal state with no bus access
            int_r <= (state_nxt == ST_INT);
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            lock_r <= 1'b0;
        // RULE_01 - a locked cycle keeps the bus into the next cycle
        else if (start || step)
            lock_r <= is_locked(state_nxt, kind_sel) ||
                (step && cur_locked);
        else if (state_r == ST_IDLE)
            lock_r <= 1'b0;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_r <= 1'b0;
            rdv_r <= 1'b0;
            rdata_r <= DATA_RST;
            next_seen_r <= 1'b0;
        end
        else
        begin
            done_r <= (state_r != ST_IDLE) && (state_nxt == ST_IDLE);
            rdv_r <= req_r && bus_ack && !write_r;
            if (req_r && bus_ack && !write_r)
                rdata_r <= bus_rdata;
            if (start)
                next_seen_r <= 1'b0;
            else if (state_r == ST_NEXT && step)
                next_seen_r <= 1'b1;
        end
    end

    assign instr_ready = ready_r;
    assign instr_done = done_r;
    assign bus_req = req_r;
    assign bus_addr = addr_r;
    assign bus_byte = byte_r;
    assign bus_write = write_r;
    assign bus_wdata = wbyte_r;
    assign bus_lock = lock_r;
    assign bus_int = int_r;
    assign rd_valid = rdv_r;
    assign rd_data = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence locked_end_s;
        req_r && bus_ack && cur_locked;
    endsequence

    sequence br8_next_s;
        state_r == ST_NEXT && kind_r == KIND_BR8 && req_r && bus_ack;
    endsequence

    sequence mod_rd_s;
        state_r == ST_OPRD && kind_r == KIND_BIT_MODIFY && req_r && bus_ack;
    endsequence

    sequence mod_next_s;
        state_r == ST_NEXT && kind_r == KIND_BIT_MODIFY && req_r && bus_ack;
    endsequence

    lock_hold_a: assert property (locked_end_s |=> lock_r) // RULE_01
        else $error("bus lock dropped right after a locked cycle");

    ext_order_a: assert property ( // RULE_02
        state_r == ST_EXT && step && state_nxt == ST_EXT |=>
        addr_r == $past(addr_r) + WORD_BYTES && !byte_r)
        else $error("extension word out of order");

    prefetch_seen_a: assert property ( // RULE_03
        done_r |-> next_seen_r || kind_r == KIND_BR16)
        else $error("instruction ended without next prefetch");

    br8_order_a: assert property ( // RULE_04
        br8_next_s |=> state_r == ST_TGT && addr_r == tgt_r && req_r)
        else $error("short branch target read missing");

    br16_int_a: assert property ( // RULE_05
        state_r == ST_INT |-> int_r && !req_r ##1
        req_r && !int_r && addr_r == tgt_r)
        else $error("long branch internal state wrong");

    bit_test_a: assert property ( // RULE_06
        state_r == ST_OPRD && kind_r == KIND_BIT_TEST && step |->
        byte_r && !lock_r ##1 lock_r && !byte_r && state_r == ST_NEXT)
        else $error("bit test sequence wrong");

    bit_mod_a: assert property ( // RULE_07
        mod_rd_s ##[1:9] mod_next_s |=>
        write_r && byte_r && addr_r == ea_r && lock_r)
        else $error("bit modify write back wrong");

    cycle_hold_a: assert property ( // RULE_08
        req_r && !bus_ack |=> req_r && $stable(addr_r) && $stable(write_r))
        else $error("bus cycle changed before completion");

endmodule // bcs_seq

// file: test/bcs_mem_model.sv
`timescale 1ns/100ps
module bcs_mem_model
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // System bus
    input wire logic bus_req,
    input wire logic [bcs_pkg::ADDR_W-1:0] bus_addr,
    output logic bus_ack,
    output logic [bcs_pkg::DATA_W-1:0] bus_rdata,
    // Wait state mask
    input wire logic [1:0] wait_max
);
    import bcs_pkg::*;
    integer seed = 32'hdd1fa7f1;
    logic [1:0] wait_r;

    ////////////////////////////////////////////////////////////////////////
    // wait states vary
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_ack <= 1'b0;
            bus_rdata <= 16'hffff;
            wait_r <= 2'h0;
        end
        else if (bus_ack && bus_req)
        begin
            bus_ack <= 1'b0;
            bus_rdata <= ~bus_rdata;
            wait_r <= 2'($random(seed)) & wait_max;
        end
        else if (bus_req && wait_r == 2'h0)
        begin
            bus_ack <= 1'b1;
            bus_rdata <= bus_addr[15:0] ^ 16'h5a5a;
        end
        else
        begin
            // Released data lines keep toggling
            bus_rdata <= ~bus_rdata;
            if (wait_r != 2'h0)
                wait_r <= wait_r - 2'h1;
        end
    end
endmodule // bcs_mem_model

// file: test/bcs_seq_tb.sv
`timescale 1ns/100ps
module bcs_seq_tb;
    import bcs_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    bcs_kind_type instr_kind = KIND_PLAIN;
    logic [EXT_W-1:0] ext_words = 3'h0;
    logic [ADDR_W-1:0] instr_addr = 24'h0, effective_address = 24'h0;
    logic [ADDR_W-1:0] branch_target = 24'h0;
    logic [BYTE_W-1:0] wr_byte = 8'h00;
    logic [1:0] wait_max = 2'h0;
    logic instr_ready, instr_done, bus_req, bus_byte, bus_write, bus_lock;
    logic bus_int, bus_ack, rd_valid;
    logic [ADDR_W-1:0] bus_addr;
    logic [BYTE_W-1:0] bus_wdata;
    logic [DATA_W-1:0] bus_rdata, rd_data, rd_exp;
    integer seed = 32'hdd1fa7f1;
    integer err_total = 0;
    integer samples_checked = 0;
    logic [35:0] seen_q[$];
    logic [35:0] exp_q[$];
    logic lock_hold = 1'b0;
    logic rd_pend = 1'b0;

    always #2.5 mclk = ~mclk;

    bcs_seq u_bcs_seq (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_kind(instr_kind), .ext_words(ext_words),
        .instr_addr(instr_addr), .effective_address(effective_address),
        .branch_target(branch_target), .wr_byte(wr_byte),
        .instr_ready(instr_ready), .instr_done(instr_done),
        .bus_req(bus_req), .bus_addr(bus_addr), .bus_byte(bus_byte),
        .bus_write(bus_write), .bus_wdata(bus_wdata), .bus_lock(bus_lock),
        .bus_int(bus_int), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
        .rd_valid(rd_valid), .rd_data(rd_data));

    bcs_mem_model u_bcs_mem_model (.mclk(mclk), .rst_n(rst_n),
        .bus_req(bus_req), .bus_addr(bus_addr), .bus_ack(bus_ack),
        .bus_rdata(bus_rdata), .wait_max(wait_max));

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [35:0] got, input logic [35:0] want);
        samples_checked++;
        if (got !== want)
        begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Bus monitor: {int, lock, write, byte, wdata, addr} per cycle
    always @(posedge mclk)
    begin
        if (rst_n && lock_hold)
            check(36'(bus_lock), 36'h1);
        if (rst_n && rd_pend)
        begin
            check(36'(rd_valid), 36'h1);
            check(36'(rd_data), 36'(rd_exp));
        end
        lock_hold = rst_n && bus_req && bus_ack && bus_lock && !bus_write;
        rd_pend = rst_n && bus_req && bus_ack && !bus_write;
        rd_exp = bus_addr[15:0] ^ 16'h5a5a;
        if (rst_n && bus_int === 1'b1)
            seen_q.push_back({4'h8, 32'h0});
        if (rst_n && bus_req && bus_ack)
            seen_q.push_back({1'b0, bus_lock & ~bus_write, bus_write,
                bus_byte, bus_write ? bus_wdata : 8'h00, bus_addr});
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic void build_exp(input bcs_kind_type k,
        input logic [2:0] n,
        input logic [ADDR_W-1:0] pc, ea, tg, input logic [BYTE_W-1:0] wb);
        logic [ADDR_W-1:0] nx;
        nx = pc + 24'(2 * (n + 1));
        exp_q.delete();
        if (k == KIND_BR8)
        begin
            exp_q.push_back({12'h000, pc + 24'h2});
            exp_q.push_back({12'h000, tg});
        end
        else if (k == KIND_BR16)
        begin
            exp_q.push_back({12'h000, pc + 24'h2});
            exp_q.push_back({4'h8, 32'h0});
            exp_q.push_back({12'h000, tg});
        end
        else
        begin
            for (int i = 1; i <= n; i++)
                exp_q.push_back({12'h000, pc + 24'(2 * i)});
            if (k == KIND_BIT_TEST)
                exp_q.push_back({12'h100, ea});
            if (k == KIND_BIT_MODIFY)
                exp_q.push_back({12'h500, ea});
            exp_q.push_back({(k == KIND_PLAIN) ? 4'h0 : 4'h4, 8'h00, nx});
            if (k == KIND_BIT_MODIFY)
                exp_q.push_back({4'h3, wb, ea});
        end
    endfunction

    task automatic run(input bcs_kind_type k, input logic [2:0] n,
        input logic [1:0] wm);
        logic [ADDR_W-1:0] pc, ea, tg;
        logic [BYTE_W-1:0] wb;
        int t;
        pc = {1'b0, 22'($random(seed)), 1'b0};
        ea = 24'($random(seed));
        tg = {1'b0, 22'($random(seed)), 1'b0};
        wb = 8'($random(seed));
        build_exp(k, n, pc, ea, tg, wb);
        seen_q.delete();
        instr_valid <= 1'b1;
        instr_kind <= k;
        ext_words <= n;
        instr_addr <= pc;
        effective_address <= ea;
        branch_target <= tg;
        wr_byte <= wb;
        wait_max <= wm;
        t = 0;
        @(posedge mclk);
        while (instr_ready !== 1'b1 && t < 50)
        begin
            @(posedge mclk);
            t++;
        end
        instr_valid <= 1'b0;
        // A refused take is treated as a hang
        if (t >= 50)
            t = 200;
        else
            t = 0;
        while (instr_done !== 1'b1 && t < 200)
        begin
            @(posedge mclk);
            t++;
        end
        if (t >= 200)
        begin
            err_total++;
            $display("wrong value at %0t: no completion", $time);
            wrap_up();
        end
        else
        begin
            check(36'(seen_q.size()), 36'(exp_q.size()));
            foreach (exp_q[i])
            begin
                if (i < seen_q.size())
                    check(seen_q[i], exp_q[i]);
            end
        end
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        check({32'h0, instr_ready, bus_req, bus_lock, bus_int},
            36'h8);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset();
        // Every kind with the longest extension, then slow bus
        for (int i = 0; i < 5; i++)
            run(bcs_kind_type'(i), 3'h4, 2'h0);
        run(KIND_BIT_MODIFY, 3'h3, 2'h3);
        run(KIND_BIT_TEST, 3'h0, 2'h3);
        run(KIND_PLAIN, 3'h0, 2'h1);
        do_reset();
        for (int i = 0; i < 40; i++)
            run(bcs_kind_type'($unsigned($random(seed)) % 5),
                3'($unsigned($random(seed)) % 5), 2'($random(seed)));
        wrap_up();
    end
endmodule // bcs_seq_tb
